// [brl_core.sv]
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module brl_core (
    input wire logic clock,
    input wire logic rst_b,
    output logic [31:0] fetch_addr,
    input wire logic instr_valid,
    input wire logic [31:0] instr_data,
    output logic instr_ready,
    output logic discard_next,
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic [1:0] mem_size,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_outstanding,
    input wire logic exc_status_wr,
    input wire logic [31:0] exc_status_in,
    output logic [31:0] machine_status_word,
    output logic [31:0] exception_status_word
);
    brl_pkg::brl_state_e state_r, state_nxt;
    logic [31:0] pc_r, pc_nxt;
    logic [31:0] instr_r, instr_nxt;

    logic [31:0] msw_r, msw_nxt;
    logic [31:0] esw_r, esw_nxt;
    logic slot_r, slot_nxt;
    logic [31:0] pend_r, pend_nxt;
    logic [15:0] imm_hi_r, imm_hi_nxt;
    logic imm_pre_r, imm_pre_nxt;
    logic [31:0] maddr_r, maddr_nxt;
    logic [1:0] msize_r, msize_nxt;
    logic [4:0] ld_rd_r, ld_rd_nxt;
    logic discard_r, discard_nxt;

    logic [31:0] ra_val, rb_val;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;

    logic [5:0] opc;
    logic [4:0] f_rd, f_ra;
    logic [31:0] simm;
    logic [31:0] seq_next;

    function automatic logic cond_holds(input logic [2:0] cc, input logic [31:0] v);
        logic z;
        logic n;
        z = (v == 32'h0000_0000);
        n = v[31];
        unique case (cc)
            brl_pkg::CC_EQ: cond_holds = z;
            brl_pkg::CC_NE: cond_holds = !z;
            brl_pkg::CC_LT: cond_holds = n;
            brl_pkg::CC_LE: cond_holds = n || z;
            brl_pkg::CC_GT: cond_holds = !n && !z;
            brl_pkg::CC_GE: cond_holds = !n;
            default: cond_holds = 1'b0;
        endcase
    endfunction

    brl_regfile #(
        .DW(brl_pkg::DATA_W),
        .AW(brl_pkg::REG_AW)
    ) u_regs (
        .clock(clock),
        .rst_b(rst_b),
        .rd_addr_a(instr_data[20:16]),
        .rd_addr_b(instr_data[15:11]),
        .rd_data_a(ra_val),
        .rd_data_b(rb_val),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    assign opc = instr_r[31:26];
    assign f_rd = instr_r[25:21];
    assign f_ra = instr_r[20:16];
    assign simm = imm_pre_r ? {imm_hi_r, instr_r[15:0]} : {{16{instr_r[15]}}, instr_r[15:0]};
    // a slot instruction hands control to the waiting target
    assign seq_next = slot_r ? pend_r : pc_r + brl_pkg::PC_STEP;

    assign fetch_addr = pc_r;
    assign instr_ready = (state_r == brl_pkg::ST_FETCH);
    assign discard_next = discard_r;
    assign mem_req = (state_r == brl_pkg::ST_LOAD);
    assign mem_addr = maddr_r;
    assign mem_size = msize_r;
    assign machine_status_word = msw_r;
    assign exception_status_word = esw_r;

    always_comb begin
        logic taken;
        logic delayed;
        logic [31:0] target;
        logic [31:0] ld_val;

        taken = 1'b0;
        delayed = 1'b0;
        target = pc_r;
        ld_val = 32'h0000_0000;
        state_nxt = state_r;
        pc_nxt = pc_r;
        instr_nxt = instr_r;
        msw_nxt = msw_r;
        esw_nxt = esw_r;
        slot_nxt = slot_r;
        pend_nxt = pend_r;
        imm_hi_nxt = imm_hi_r;
        imm_pre_nxt = imm_pre_r;
        maddr_nxt = maddr_r;
        msize_nxt = msize_r;
        ld_rd_nxt = ld_rd_r;

        discard_nxt = 1'b0;
        wr_en = 1'b0;
        wr_addr = f_rd;
        wr_data = 32'h0000_0000;

        if (exc_status_wr) begin
            esw_nxt = exc_status_in;
        end

        unique case (state_r)
            brl_pkg::ST_FETCH: begin
                if (instr_valid) begin
                    instr_nxt = instr_data;
                    state_nxt = brl_pkg::ST_EXEC;
                end
            end

            brl_pkg::ST_EXEC: begin
                state_nxt = brl_pkg::ST_FETCH;
                imm_pre_nxt = 1'b0;
                unique case (opc)
                    brl_pkg::OP_BR_REG, brl_pkg::OP_BR_IMM: begin
                        if (opc == brl_pkg::OP_BR_IMM && f_ra == brl_pkg::BAR_CODE) begin
                            state_nxt = brl_pkg::ST_BAR;
                        end else begin
                            target = (opc == brl_pkg::OP_BR_REG) ? rb_val : simm;
                            if (!f_ra[brl_pkg::CTL_ABS]) begin
                                target = pc_r + target;
                            end
                            taken = 1'b1;
                            delayed = f_ra[brl_pkg::CTL_DELAY];
                            if (f_ra[brl_pkg::CTL_LINK] || f_ra == brl_pkg::CTL_BREAK) begin
                                wr_en = 1'b1;
                                wr_data = pc_r;
                            end
                            if (f_ra == brl_pkg::CTL_BREAK) begin
                                msw_nxt[brl_pkg::MSW_BIP] = 1'b1;
                            end
                        end
                    end

                    brl_pkg::OP_BCC_REG, brl_pkg::OP_BCC_IMM: begin
                        // condition msb marks the delayed variant
                        delayed = f_rd[4];
                        taken = cond_holds(f_rd[2:0], ra_val) && (f_rd[3] == 1'b0);
                        if (opc == brl_pkg::OP_BCC_REG) begin
                            target = pc_r + rb_val;
                        end else begin
                            target = pc_r + simm;
                        end
                    end

                    brl_pkg::OP_RET: begin
                        target = ra_val + simm;
                        taken = 1'b1;
                        delayed = 1'b1;
                        if (f_rd == brl_pkg::RET_INT) begin
                            msw_nxt[brl_pkg::MSW_IE] = 1'b1;
                        end
                        if (f_rd == brl_pkg::RET_BRK) begin
                            msw_nxt[brl_pkg::MSW_BIP] = 1'b0;
                        end
                        if (f_rd == brl_pkg::RET_EXC) begin
                            msw_nxt[brl_pkg::MSW_EE] = 1'b1;
                            msw_nxt[brl_pkg::MSW_EIP] = 1'b0;
                            esw_nxt = brl_pkg::ESW_RESET;
                        end
                    end

                    brl_pkg::OP_ORI: begin
                        wr_en = 1'b1;
                        wr_data = ra_val | simm;
                    end

                    brl_pkg::OP_ANDI: begin
                        wr_en = 1'b1;
                        wr_data = ra_val & simm;
                    end

                    brl_pkg::OP_XORI: begin
                        wr_en = 1'b1;
                        wr_data = ra_val ^ simm;
                    end

                    brl_pkg::OP_ANDNI: begin
                        wr_en = 1'b1;
                        wr_data = ra_val & ~simm;
                    end

                    brl_pkg::OP_IMM: begin
                        imm_hi_nxt = instr_r[15:0];
                        imm_pre_nxt = 1'b1;
                    end

                    brl_pkg::OP_LBU, brl_pkg::OP_LHU, brl_pkg::OP_LBUI, brl_pkg::OP_LHUI: begin
                        if (opc == brl_pkg::OP_LBU || opc == brl_pkg::OP_LHU) begin
                            maddr_nxt = ra_val + rb_val;
                        end else begin
                            maddr_nxt = ra_val + simm;
                        end
                        msize_nxt = opc[0] ? brl_pkg::SIZE_HALF : brl_pkg::SIZE_BYTE;
                        ld_rd_nxt = f_rd;
                        state_nxt = brl_pkg::ST_LOAD;
                    end

                    default: begin
                    end
                endcase

                if (state_nxt == brl_pkg::ST_FETCH) begin
                    if (slot_r) begin
                        // slot done: branches inside a slot are not honoured
                        pc_nxt = pend_r;
                        slot_nxt = 1'b0;
                    end else if (taken && delayed) begin
                        pend_nxt = target;
                        slot_nxt = 1'b1;
                        pc_nxt = pc_r + brl_pkg::PC_STEP;
                    end else if (taken) begin
                        pc_nxt = target;
                        discard_nxt = 1'b1;
                    end else begin
                        pc_nxt = pc_r + brl_pkg::PC_STEP;
                    end
                end
            end

            brl_pkg::ST_LOAD: begin
                if (mem_ack) begin
                    if (msize_r == brl_pkg::SIZE_HALF) begin
                        ld_val = {16'h0000, mem_rdata[15:0]};
                    end else begin
                        ld_val = {24'h00_0000, mem_rdata[7:0]};
                    end
                    wr_en = 1'b1;
                    wr_addr = ld_rd_r;
                    wr_data = ld_val;
                    pc_nxt = seq_next;
                    slot_nxt = 1'b0;
                    state_nxt = brl_pkg::ST_FETCH;
                end
            end

            brl_pkg::ST_BAR: begin
                if (!mem_outstanding) begin
                    pc_nxt = seq_next;
                    slot_nxt = 1'b0;
                    state_nxt = brl_pkg::ST_FETCH;
                end
            end
            default: begin
                state_nxt = brl_pkg::ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= brl_pkg::ST_FETCH;
            pc_r <= brl_pkg::PC_RESET;
            instr_r <= 32'h0000_0000;
            msw_r <= brl_pkg::MSW_RESET;
            esw_r <= brl_pkg::ESW_RESET;
            slot_r <= 1'b0;
            pend_r <= 32'h0000_0000;
            imm_hi_r <= 16'h0000;
            imm_pre_r <= 1'b0;
            maddr_r <= 32'h0000_0000;
            msize_r <= brl_pkg::SIZE_BYTE;
            ld_rd_r <= 5'h00;
            discard_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            instr_r <= instr_nxt;
            msw_r <= msw_nxt;
            esw_r <= esw_nxt;
            slot_r <= slot_nxt;
            pend_r <= pend_nxt;
            imm_hi_r <= imm_hi_nxt;
            imm_pre_r <= imm_pre_nxt;
            maddr_r <= maddr_nxt;
            msize_r <= msize_nxt;
            ld_rd_r <= ld_rd_nxt;
            discard_r <= discard_nxt;
        end
    end
endmodule // brl_core

// [brl_pkg.sv]
package brl_pkg;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_AW = 5;
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    // opcode field codes
    localparam logic [5:0] OP_BR_REG = 6'h26;
    localparam logic [5:0] OP_BCC_REG = 6'h27;
    localparam logic [5:0] OP_ORI = 6'h28;
    localparam logic [5:0] OP_ANDI = 6'h29;
    localparam logic [5:0] OP_XORI = 6'h2a;
    localparam logic [5:0] OP_ANDNI = 6'h2b;
    localparam logic [5:0] OP_IMM = 6'h2c;
    localparam logic [5:0] OP_RET = 6'h2d;
    localparam logic [5:0] OP_BR_IMM = 6'h2e;
    localparam logic [5:0] OP_BCC_IMM = 6'h2f;
    localparam logic [5:0] OP_LBU = 6'h30;
    localparam logic [5:0] OP_LHU = 6'h31;
    localparam logic [5:0] OP_LBUI = 6'h38;
    localparam logic [5:0] OP_LHUI = 6'h39;
    // branch control field bits and whole-field codes
    localparam int unsigned CTL_DELAY = 4;
    localparam int unsigned CTL_ABS = 3;
    localparam int unsigned CTL_LINK = 2;
    localparam logic [4:0] CTL_BREAK = 5'h0c;
    localparam logic [4:0] BAR_CODE = 5'h02;
    // return kinds
    localparam logic [4:0] RET_SUB = 5'h10;
    localparam logic [4:0] RET_INT = 5'h11;
    localparam logic [4:0] RET_BRK = 5'h12;
    localparam logic [4:0] RET_EXC = 5'h14;
    // condition codes
    localparam logic [2:0] CC_EQ = 3'h0;
    localparam logic [2:0] CC_NE = 3'h1;
    localparam logic [2:0] CC_LT = 3'h2;
    localparam logic [2:0] CC_LE = 3'h3;
    localparam logic [2:0] CC_GT = 3'h4;
    localparam logic [2:0] CC_GE = 3'h5;
    // machine status word bit positions; status word reset values
    localparam int unsigned MSW_IE = 1;
    localparam int unsigned MSW_BIP = 3;
    localparam int unsigned MSW_EE = 8;
    localparam int unsigned MSW_EIP = 9;
    localparam logic [31:0] MSW_RESET = 32'h0000_0000;
    localparam logic [31:0] ESW_RESET = 32'h0000_0000;
    // load sizes on the memory port
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    typedef enum logic [3:0] {
        ST_FETCH = 4'b0001,
        ST_EXEC = 4'b0010,
        ST_LOAD = 4'b0100,
        ST_BAR = 4'b1000
    } brl_state_e;
endpackage

// [brl_regfile.sv]
`timescale 1ns/1ps
module brl_regfile #(
    parameter int unsigned DW = 32,
    parameter int unsigned AW = 5
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [AW-1:0] rd_addr_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic [DW-1:0] rd_data_a,
    output logic [DW-1:0] rd_data_b,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];
    logic [DW-1:0] rd_a_nxt;
    logic [DW-1:0] rd_b_nxt;

    // register zero always reads as zero
    always_comb begin
        rd_a_nxt = (rd_addr_a == '0) ? '0 : mem_r[rd_addr_a];
        rd_b_nxt = (rd_addr_b == '0) ? '0 : mem_r[rd_addr_b];
    end

    always_ff @(posedge clock) begin
        if (wr_en && (wr_addr != '0)) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_a <= '0;
            rd_data_b <= '0;
        end else begin
            rd_data_a <= rd_a_nxt;
            rd_data_b <= rd_b_nxt;
        end
    end
endmodule // brl_regfile

// [brl_core_assertions.sv]
`timescale 1ns/1ps
module brl_core_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [31:0] fetch_addr,
    input wire logic instr_valid,
    input wire logic [31:0] instr_data,
    input wire logic instr_ready,
    input wire logic discard_next,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [1:0] mem_size,
    input wire logic mem_ack,
    input wire logic mem_outstanding,
    input wire logic [31:0] machine_status_word,
    input wire logic [31:0] exception_status_word
);
    logic acc;
    logic [31:0] word_r;
    logic [31:0] word_nxt;
    logic [31:0] pc_r;
    logic [31:0] pc_nxt;
    logic bar_r;
    logic bar_nxt;
    logic [5:0] wop;
    logic [4:0] wd;
    logic [4:0] wa;
    logic dly;
    assign acc = instr_valid && instr_ready;
    assign wop = word_r[31:26];
    assign wd = word_r[25:21];
    assign wa = word_r[20:16];
    assign dly = (wop == brl_pkg::OP_BR_REG || wop == brl_pkg::OP_BR_IMM) ? wa[4]
        : (wop == brl_pkg::OP_BCC_REG || wop == brl_pkg::OP_BCC_IMM
        || wop == brl_pkg::OP_RET) && wd[4];
    // last accepted word, its address and whether it was a barrier
    always_comb begin
        word_nxt = word_r;
        pc_nxt = pc_r;
        bar_nxt = bar_r;
        if (acc) begin
            word_nxt = instr_data;
            pc_nxt = fetch_addr;
            bar_nxt = instr_data[31:26] == brl_pkg::OP_BR_IMM
                && instr_data[20:16] == brl_pkg::BAR_CODE;
        end
    end
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            word_r <= 32'h0;
            pc_r <= 32'h0;
            bar_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            pc_r <= pc_nxt;
            bar_r <= bar_nxt;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_byte_size: assert property (
        mem_req && wop == brl_pkg::OP_LBU |-> mem_size == brl_pkg::SIZE_BYTE)
        else $error("byte load size wrong");
    a_half_size: assert property (
        mem_req && wop == brl_pkg::OP_LHU |-> mem_size == brl_pkg::SIZE_HALF)
        else $error("halfword load size wrong");
    a_req_holds: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_size))
        else $error("load request dropped or changed");
    a_load_ends: assert property (
        mem_req && mem_ack |=> !mem_req && instr_ready && fetch_addr == pc_r + 32'h4)
        else $error("load did not finish to next word");
    a_bar_waits: assert property (
        bar_r && mem_outstanding |-> !instr_ready)
        else $error("barrier let go while memory busy");
    a_bar_next: assert property (
        $rose(instr_ready) && bar_r |-> fetch_addr == pc_r + 32'h4)
        else $error("barrier did not step four bytes");
    a_abs_jump: assert property (
        $rose(instr_ready) && wop == brl_pkg::OP_BR_IMM && wa == 5'h08
        |-> discard_next && fetch_addr == {{16{word_r[15]}}, word_r[15:0]})
        else $error("absolute jump target wrong");
    a_delay_keeps: assert property (
        $rose(instr_ready) && dly |-> !discard_next && fetch_addr == pc_r + 32'h4)
        else $error("delayed form skipped its slot");
    a_exc_return: assert property (
        $rose(instr_ready) && wop == brl_pkg::OP_RET && wd == brl_pkg::RET_EXC
        |-> exception_status_word == 32'h0 && machine_status_word[brl_pkg::MSW_EE]
        && !machine_status_word[brl_pkg::MSW_EIP])
        else $error("exception return status wrong");
    a_break_flag: assert property (
        $rose(instr_ready) && (wop == brl_pkg::OP_BR_REG || wop == brl_pkg::OP_BR_IMM)
        && wa == brl_pkg::CTL_BREAK |-> machine_status_word[brl_pkg::MSW_BIP])
        else $error("break flag not set");
    c_bar_stall: cover property (bar_r && mem_outstanding);
    c_slow_load: cover property (mem_req && !mem_ack);
    c_discard: cover property (discard_next);
endmodule // brl_core_chk

// [brl_mem_model.sv]
`timescale 1ns/1ps
module brl_mem_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] lat,
    input wire logic [31:0] fetch_addr,
    output logic instr_valid,
    output logic [31:0] instr_data,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    output logic mem_outstanding
);
    logic [31:0] imem [0:63];
    logic [3:0] wait_r;
    logic [3:0] busy_r;
    logic [31:0] dat;
    // data pattern per address; inverted when not answering
    assign dat = {4{mem_addr[7:0] ^ 8'hc3}};
    assign instr_valid = rst_b;
    assign instr_data = rst_b ? imem[fetch_addr[7:2]] : ~imem[fetch_addr[7:2]];
    assign mem_ack = mem_req && wait_r == lat;
    assign mem_rdata = mem_ack ? dat : ~dat;
    assign mem_outstanding = busy_r != 4'h0;
    // answer after lat cycles, then stay busy a while like a posted write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= 4'h0;
            busy_r <= 4'h0;
        end else begin
            wait_r <= (mem_ack || !mem_req) ? 4'h0 : wait_r + 4'h1;
            busy_r <= mem_ack ? lat + 4'h2 : busy_r - {3'h0, mem_outstanding};
        end
    end
endmodule // brl_mem_model

// [tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic clock;
    logic rst_b;
    logic exc_status_wr;
    logic [31:0] exc_status_in;
    logic [3:0] lat;
    logic [31:0] fetch_addr;
    logic instr_valid;
    logic [31:0] instr_data;
    logic instr_ready;
    logic discard_next;
    logic mem_req;
    logic [31:0] mem_addr;
    logic [1:0] mem_size;
    logic mem_ack;
    logic [31:0] mem_rdata;
    logic mem_outstanding;
    logic [31:0] machine_status_word;
    logic [31:0] exception_status_word;
    int n_errors = 0;
    int n_checks = 0;
    logic [31:0] tr[$];
    logic [31:0] ma[$];
    logic [1:0] ms[$];
    brl_core u_dut (.clock, .rst_b, .fetch_addr, .instr_valid, .instr_data, .instr_ready,
        .discard_next, .mem_req, .mem_addr, .mem_size, .mem_ack, .mem_rdata,
        .mem_outstanding, .exc_status_wr, .exc_status_in, .machine_status_word,
        .exception_status_word);
    brl_mem_model u_mem (.clock, .rst_b, .lat, .fetch_addr, .instr_valid, .instr_data,
        .mem_req, .mem_addr, .mem_ack, .mem_rdata, .mem_outstanding);
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // record accepted fetch addresses and finished loads
    always @(negedge clock) begin
        if (rst_b && instr_valid && instr_ready) begin
            tr.push_back(fetch_addr);
        end
        if (rst_b && mem_req && mem_ack) begin
            ma.push_back(mem_addr);
            ms.push_back(mem_size);
        end
    end
    function automatic logic [31:0] ins(logic [5:0] o, logic [4:0] d, logic [4:0] a,
        logic [15:0] i);
        return {o, d, a, i};
    endfunction
    function automatic bit taken(int c, int s);
        case (c % 6)
            0: return s == 0;
            1: return s != 0;
            2: return s < 0;
            3: return s <= 0;
            4: return s > 0;
            default: return s >= 0;
        endcase
    endfunction
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic hold();
        @(posedge clock);
        rst_b <= 1'b0;
        @(negedge clock);
        for (int i = 0; i < 64; i++) begin
            u_mem.imem[i] = 32'h0;
        end
    endtask
    task automatic go();
        @(posedge clock);
        tr.delete();
        ma.delete();
        ms.delete();
        rst_b <= 1'b1;
    endtask
    task automatic await(int k, int m);
        int c;
        c = 0;
        while ((tr.size() < k || ma.size() < m) && c < 400) begin
            @(posedge clock);
            c++;
        end
        if (tr.size() < k || ma.size() < m) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, tr.size(), k);
            final_report();
        end
    endtask
    task automatic t_cond();
        int s;
        bit tk;
        bit dl;
        logic [4:0] cc;
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 12; c++) begin
                for (int k = 0; k < 3; k++) begin
                    s = k == 0 ? -1 : (k == 1 ? 0 : 5);
                    dl = c >= 6;
                    cc = {dl, 1'b0, 3'(c % 6)};
                    tk = taken(c, s);
                    hold();
                    u_mem.imem[0] = ins(brl_pkg::OP_ORI, 5'd1, 5'd0, 16'(s));
                    u_mem.imem[1] = ins(brl_pkg::OP_ORI, 5'd2, 5'd0, 16'h40);
                    u_mem.imem[2] = f ? ins(brl_pkg::OP_BCC_IMM, cc, 5'd1, 16'h40)
                        : ins(brl_pkg::OP_BCC_REG, cc, 5'd1, 16'h1000);
                    go();
                    await(5, 0);
                    `CHK(tr[3], (tk && !dl) ? 32'h48 : 32'hc)
                    `CHK(tr[4], !tk ? 32'h10 : (dl ? 32'h48 : 32'h4c))
                end
            end
        end
        $display("conditional branches done");
    endtask
    task automatic t_uncond();
        logic [4:0] cl [7] = '{5'h00, 5'h10, 5'h14, 5'h1c, 5'h08, 5'h18, 5'h0c};
        logic [4:0] ct;
        for (int f = 0; f < 2; f++) begin
            for (int j = 0; j < 7; j++) begin
                ct = cl[j];
                hold();
                u_mem.imem[0] = ins(brl_pkg::OP_ORI, 5'd2, 5'd0, 16'h40);
                u_mem.imem[1] = ins(brl_pkg::OP_ORI, 5'd3, 5'd0, 16'h80);
                u_mem.imem[2] = f ? ins(brl_pkg::OP_BR_IMM, 5'd3, ct, 16'h40)
                    : ins(brl_pkg::OP_BR_REG, 5'd3, ct, 16'h1000);
                u_mem.imem[16] = ins(brl_pkg::OP_LBU, 5'd4, 5'd3, 16'h0);
                u_mem.imem[18] = u_mem.imem[16];
                go();
                await(5, 1);
                `CHK(tr[ct[4] ? 4 : 3], ct[3] ? 32'h40 : 32'h48)
                `CHK(ma[0], ct[2] ? 32'h8 : 32'h80)
                `CHK(machine_status_word[brl_pkg::MSW_BIP], ct == brl_pkg::CTL_BREAK)
            end
        end
        $display("unconditional branches done");
    endtask
    task automatic t_ret();
        logic [4:0] kl [4] = '{5'h10, 5'h11, 5'h12, 5'h14};
        logic [4:0] kd;
        logic [31:0] e;
        for (int j = 0; j < 4; j++) begin
            kd = kl[j];
            e = 32'h0;
            e[brl_pkg::MSW_IE] = kd == brl_pkg::RET_INT;
            e[brl_pkg::MSW_BIP] = kd != brl_pkg::RET_BRK;
            e[brl_pkg::MSW_EE] = kd == brl_pkg::RET_EXC;
            hold();
            u_mem.imem[0] = ins(brl_pkg::OP_ORI, 5'd2, 5'd0, 16'h40);
            u_mem.imem[1] = ins(brl_pkg::OP_BR_IMM, 5'd3, brl_pkg::CTL_BREAK, 16'h20);
            u_mem.imem[8] = ins(brl_pkg::OP_RET, kd, 5'd2, 16'h10);
            u_mem.imem[20] = ins(brl_pkg::OP_LBU, 5'd4, 5'd2, 16'h0);
            go();
            await(2, 0);
            exc_status_wr <= 1'b1;
            exc_status_in <= 32'h1234_0005;
            @(posedge clock);
            exc_status_wr <= 1'b0;
            await(5, 1);
            `CHK({tr[3], tr[4]}, {32'h24, 32'h50})
            `CHK(machine_status_word, e)
            `CHK(exception_status_word, kd == 5'h14 ? 32'h0 : 32'h1234_0005)
        end
        $display("returns done");
    endtask
    task automatic t_load();
        logic [7:0] d;
        d = 8'h03 ^ 8'hc3;
        for (int l = 0; l < 2; l++) begin
            hold();
            lat <= 4'(l * 3);
            u_mem.imem[0] = ins(brl_pkg::OP_ORI, 5'd1, 5'd0, 16'h1001);
            u_mem.imem[1] = ins(brl_pkg::OP_ORI, 5'd2, 5'd0, 16'h0102);
            u_mem.imem[2] = ins(brl_pkg::OP_LBU, 5'd5, 5'd1, 16'h1000);
            u_mem.imem[3] = ins(brl_pkg::OP_LHU, 5'd6, 5'd1, 16'h1000);
            u_mem.imem[4] = ins(brl_pkg::OP_LBU, 5'd7, 5'd5, 16'h3000);
            u_mem.imem[5] = ins(brl_pkg::OP_BR_IMM, 5'd0, brl_pkg::BAR_CODE, 16'h4);
            u_mem.imem[6] = ins(brl_pkg::OP_IMM, 5'd0, 5'd0, 16'h0001);
            u_mem.imem[7] = ins(brl_pkg::OP_LHUI, 5'd8, 5'd0, 16'h2345);
            u_mem.imem[8] = ins(brl_pkg::OP_XORI, 5'd9, 5'd1, 16'h00ff);
            u_mem.imem[9] = ins(brl_pkg::OP_ANDI, 5'd9, 5'd9, 16'hfff0);
            u_mem.imem[10] = ins(brl_pkg::OP_LBUI, 5'd10, 5'd9, 16'h0000);
            go();
            await(11, 5);
            `CHK({ma[0], ma[1]}, {32'h1103, 32'h1103})
            `CHK({ms[0], ms[1], ms[2]}, 6'b00_01_00)
            `CHK(ma[2], {24'h0, d} + {16'h0, d, d})
            `CHK(tr[6], 32'h18)
            `CHK({ma[3], ma[4]}, {32'h0001_2345, 32'h0000_10f0})
            `CHK({ms[3], ms[4]}, 4'b01_00)
        end
        $display("loads and barrier done");
    endtask
    initial begin
        rst_b = 1'b0;
        exc_status_wr = 1'b0;
        exc_status_in = 32'h0;
        lat = 4'h0;
        repeat (16) @(posedge clock);
        t_cond();
        t_uncond();
        t_ret();
        t_load();
        final_report();
    end
endmodule // tb
bind brl_core brl_core_chk u_chk (.clock, .rst_b, .fetch_addr, .instr_valid, .instr_data,
    .instr_ready, .discard_next, .mem_req, .mem_addr, .mem_size, .mem_ack,
    .mem_outstanding, .machine_status_word, .exception_status_word);
